/* File: iox_ctl_model.sv */
// behavioural serial bus controller facing the expander
module iox_ctl_model (
  // clock
  input wire logic clk,
  // bus lines, sda as resolved wire
  input wire logic sda,
  output logic scl,
  output logic sda_oe,
  // end-of-transfer report
  output logic got,
  output logic [7:0] dat
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  localparam int PH = 8; // cycles per scl phase, slow enough for the filter
  // lines idle high, scl stands still between frames
  initial begin
    scl = 1;
    sda_oe = 0;
    got = 0;
    dat = 0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start or repeated start: sda falls with scl high
  task automatic st();
    sda_oe <= 0; w(PH); scl <= 1; w(PH); sda_oe <= 1; w(PH); scl <= 0;
  endtask
  // stop: sda rises with scl high
  task automatic sp();
    w(PH / 2); sda_oe <= 1; w(PH / 2); scl <= 1; w(PH); sda_oe <= 0; w(PH);
  endtask
  // eight bits msb first plus the ack slot, sampled mid-high
  task automatic by(input logic [8:0] t, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      w(PH / 2); sda_oe <= !t[i]; w(PH / 2); scl <= 1; w(PH / 2); r[i] = sda; w(PH / 2); scl <= 0;
    end
  endtask
  task automatic report(input logic [7:0] v);
    got <= 1; dat <= v; w(1); got <= 0;
  endtask
  // address, command, data, stop; reports all acks
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    logic [8:0] r0, r1, r2;
    st(); by({a, 2'b01}, r0); by({c, 1'b1}, r1); by({d, 1'b1}, r2); sp();
    report({7'h00, !r0[0] && !r1[0] && !r2[0]});
  endtask
  // command write, repeated start, one byte read with nack
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    logic [8:0] r0, r1, r2, r3;
    st(); by({a, 2'b01}, r0); by({c, 1'b1}, r1); st(); by({a, 2'b11}, r2); by(9'h1FF, r3); sp();
    report(r3[8:1]);
  endtask
endmodule

/* File: iox_expander.sv */
// sixteen-port i2c expander with input change detection
module iox_expander
  import iox_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // serial bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // configuration pins
  input wire logic ADDR_SELECT_LO,
  input wire logic ADDR_SELECT_HI,
  input wire logic BUS_ABORT_N,
  // group a, open-drain ports
  input wire logic [7:0] OPEN_DRAIN_PORTS_IN,
  output logic [7:0] OPEN_DRAIN_PORTS_OUT,
  output logic [7:0] OPEN_DRAIN_PORTS_OE,
  // group b, push-pull ports
  input wire logic [7:0] PUSH_PULL_PORTS_IN,
  output logic [7:0] PUSH_PULL_PORTS_OUT,
  output logic [7:0] PUSH_PULL_PORTS_OE,
  // interrupt, open drain
  output logic CHANGE_IRQ_N_OUT,
  output logic CHANGE_IRQ_N_OE
);
`include "iox_params.svh"
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  iox_bus_s bus; // filtered scl and sda
  iox_bus_s bus_d_ff; // previous filtered levels
  logic [15:0] pin_s1_ff; // first stage, read only by second
  logic [15:0] pin_s2_ff; // synced port levels
  logic [2:0] cfg_s1_ff; // abort and select pins, first stage
  logic [2:0] cfg_s2_ff; // second stage
  // scl glitch filter
  iox_filter #(.LEN(`IOX_FILT_CYC)) u_scl (
    .clk(CLK),
    .rst(SYS_RST),
    .pin(SCL_IN),
    .level(bus.scl)
  );
  // sda glitch filter
  iox_filter #(.LEN(`IOX_FILT_CYC)) u_sda (
    .clk(CLK),
    .rst(SYS_RST),
    .pin(SDA_IN),
    .level(bus.sda)
  );
  // ports and straps through two flops each
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pin_s1_ff <= 16'hFFFF;
      pin_s2_ff <= 16'hFFFF;
      cfg_s1_ff <= 3'h7;
      cfg_s2_ff <= 3'h7;
    end else begin
      pin_s1_ff <= {PUSH_PULL_PORTS_IN, OPEN_DRAIN_PORTS_IN};
      pin_s2_ff <= pin_s1_ff;
      cfg_s1_ff <= {BUS_ABORT_N, ADDR_SELECT_HI, ADDR_SELECT_LO};
      cfg_s2_ff <= cfg_s1_ff;
    end
  end
  wire abort = ~cfg_s2_ff[2];
  wire [1:0] sel = cfg_s2_ff[1:0];
  // ----------------------------------------
  // bus condition decode
  // ----------------------------------------
  wire scl_rise = bus.scl & ~bus_d_ff.scl;
  wire scl_fall = ~bus.scl & bus_d_ff.scl;
  wire start_c = bus.scl & bus_d_ff.scl & bus_d_ff.sda & ~bus.sda;
  wire stop_c = bus.scl & bus_d_ff.scl & ~bus_d_ff.sda & bus.sda;
  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  iox_state_e st_ff; // serial engine state
  logic [7:0] sh_ff; // shift register
  logic [3:0] bit_ff; // bit counter
  logic [2:0] cmd_ff; // selected register
  logic got_cmd_ff; // command byte received in this write
  logic rd_ff; // a read address was taken since the last stop or abort
  logic nack_ff; // controller did not acknowledge
  logic sda_low_ff; // drive sda low
  logic strap_ff; // one-cycle pulse that loads the defaults
  iox_group_s grp_ff [2]; // output, direction, mask per group
  logic [15:0] snap_ff; // snapshot from last access
  logic [1:0] pend_ff; // pending change per group
  // ----------------------------------------
  // read mux and change detection
  // ----------------------------------------
  wire addr_hit = (sh_ff[7:1] == {`IOX_ADDR_HI, sel});
  wire is_read = sh_ff[0];
  wire [15:0] dir_all = {grp_ff[1].dir, grp_ff[0].dir};
  wire [15:0] msk_all = {grp_ff[1].msk, grp_ff[0].msk};
  // only inputs, unmasked, different from snapshot; output writes never count
  wire [15:0] diff = (pin_s2_ff ^ snap_ff) & dir_all & ~msk_all;
  wire [1:0] chg = {|diff[15:8], |diff[7:0]};
  wire rd_port_a = (cmd_ff == `IOX_CMD_IN_A) || (cmd_ff == `IOX_CMD_OUT_A);
  wire rd_port_b = (cmd_ff == `IOX_CMD_IN_B) || (cmd_ff == `IOX_CMD_OUT_B);
  wire addr_ack = (st_ff == IOX_AACK) & scl_fall & addr_hit;
  wire [7:0] rd_data =
    (cmd_ff == `IOX_CMD_IN_A) ? pin_s2_ff[7:0] :
    (cmd_ff == `IOX_CMD_IN_B) ? pin_s2_ff[15:8] :
    (cmd_ff == `IOX_CMD_OUT_A) ? grp_ff[0].outv :
    (cmd_ff == `IOX_CMD_OUT_B) ? grp_ff[1].outv :
    (cmd_ff == `IOX_CMD_DIR_A) ? grp_ff[0].dir :
    (cmd_ff == `IOX_CMD_DIR_B) ? grp_ff[1].dir :
    (cmd_ff == `IOX_CMD_MSK_A) ? grp_ff[0].msk : grp_ff[1].msk;
  // data byte write strobe, on the falling edge of the eighth bit
  wire wr_data = (st_ff == IOX_WBYT) & scl_fall & (bit_ff == 4'h8) & got_cmd_ff;
  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  // abort and stop both land in idle; sda is let go at once
  always_ff @(posedge CLK) begin
    bus_d_ff <= bus;
    if (SYS_RST || abort || stop_c) begin
      st_ff <= IOX_IDLE;
      bit_ff <= 4'h0;
      sda_low_ff <= 1'b0;
      got_cmd_ff <= 1'b0;
      rd_ff <= 1'b0;
      nack_ff <= 1'b0;
      sh_ff <= 8'h00;
      if (SYS_RST)
        cmd_ff <= `IOX_CMD_IN_A;
    end else if (start_c) begin
      st_ff <= IOX_ADDR;
      bit_ff <= 4'h0;
      sda_low_ff <= 1'b0;
      got_cmd_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        IOX_IDLE: begin
          sda_low_ff <= 1'b0;
        end
        IOX_ADDR, IOX_WBYT: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], bus.sda};
            bit_ff <= bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'h8) begin
            bit_ff <= 4'h0;
            if (st_ff == IOX_ADDR) begin
              st_ff <= IOX_AACK;
              sda_low_ff <= addr_hit;
            end else begin
              st_ff <= IOX_WACK;
              sda_low_ff <= 1'b1;
              if (!got_cmd_ff)
                cmd_ff <= sh_ff[2:0];
              got_cmd_ff <= 1'b1;
            end
          end
        end
        IOX_AACK: begin
          if (scl_fall) begin
            if (!addr_hit) begin
              st_ff <= IOX_IDLE;
              sda_low_ff <= 1'b0;
            end else if (is_read) begin
              rd_ff <= 1'b1;
              st_ff <= IOX_RBYT;
              sh_ff <= rd_data;
              sda_low_ff <= ~rd_data[7];
              bit_ff <= 4'h1;
            end else begin
              st_ff <= IOX_WBYT;
              sda_low_ff <= 1'b0;
            end
          end
        end
        IOX_WACK: begin
          if (scl_fall) begin
            st_ff <= IOX_WBYT;
            sda_low_ff <= 1'b0;
          end
        end
        IOX_RBYT: begin
          if (scl_fall) begin
            if (bit_ff == 4'h8) begin
              st_ff <= IOX_RACK;
              sda_low_ff <= 1'b0;
            end else begin
              sda_low_ff <= ~sh_ff[3'(4'h7 - bit_ff)];
              bit_ff <= bit_ff + 4'h1;
            end
          end
        end
        IOX_RACK: begin
          if (scl_rise)
            nack_ff <= bus.sda;
          if (scl_fall) begin
            // on nack go idle and stay off the bus until the next start
            if (nack_ff) begin
              st_ff <= IOX_IDLE;
            end else begin
              st_ff <= IOX_RBYT;
              sh_ff <= rd_data;
              sda_low_ff <= ~rd_data[7];
              bit_ff <= 4'h1;
            end
          end
        end
      endcase
    end
  end
  // ----------------------------------------
  // port registers and detection
  // ----------------------------------------
  // defaults come from the strap after the synchroniser has filled
  wire [15:0] dflt = {{4{sel[1]}}, {4{sel[0]}}, {4{sel[1]}}, {4{sel[0]}}};
  for (genvar g = 0; g < 2; g++) begin : g_grp
    always_ff @(posedge CLK) begin
      if (SYS_RST) begin
        grp_ff[g].outv <= 8'hFF;
        grp_ff[g].dir <= `IOX_DIR_RST;
        grp_ff[g].msk <= `IOX_MSK_RST;
        snap_ff[g*8 +: 8] <= 8'h00;
        pend_ff[g] <= 1'b0;
      end else begin
        if (strap_ff)
          grp_ff[g].outv <= dflt[g*8 +: 8];
        else if (wr_data && cmd_ff == 3'(`IOX_CMD_OUT_A + g))
          grp_ff[g].outv <= sh_ff;
        if (wr_data && cmd_ff == 3'(`IOX_CMD_DIR_A + g))
          grp_ff[g].dir <= sh_ff;
        if (wr_data && cmd_ff == 3'(`IOX_CMD_MSK_A + g))
          grp_ff[g].msk <= sh_ff;
        // snapshot on every address acknowledge, and at power-up
        if (strap_ff || addr_ack)
          snap_ff[g*8 +: 8] <= pin_s2_ff[g*8 +: 8];
        // clear only for a read of this group's input or output register; an input read carries
        // the level seen at this acknowledge, so clearing there drops nothing
        // a change on a group not read is kept even at the acknowledge
        if (addr_ack && is_read && (g == 0 ? rd_port_a : rd_port_b))
          pend_ff[g] <= 1'b0;
        else if (chg[g] && !strap_ff)
          pend_ff[g] <= 1'b1;
      end
    end
  end
  // strap load waits for the select pins to cross into this domain
  logic [1:0] strap_cnt_ff; // cycles since reset release
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      strap_cnt_ff <= 2'h0;
      strap_ff <= 1'b0;
    end else begin
      if (strap_cnt_ff != 2'h3)
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      strap_ff <= (strap_cnt_ff == 2'h2);
    end
  end
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  wire [15:0] out_all = {grp_ff[1].outv, grp_ff[0].outv};
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low_ff;
  // group a open drain: drives only a low output
  assign OPEN_DRAIN_PORTS_OUT = 8'h00;
  assign OPEN_DRAIN_PORTS_OE = ~grp_ff[0].dir & ~grp_ff[0].outv;
  assign PUSH_PULL_PORTS_OUT = grp_ff[1].outv;
  assign PUSH_PULL_PORTS_OE = ~grp_ff[1].dir;
  // interrupt stays through a bus abort; only reads clear it
  assign CHANGE_IRQ_N_OUT = 1'b0;
  assign CHANGE_IRQ_N_OE = |pend_ff;
  wire unused_ok = ^out_all | rd_ff;
endmodule

/* File: iox_expander_properties.sv */
// port-level assertions for the sixteen-port expander
module iox_expander_chk
  import iox_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // serial and strap pins
  input wire logic SCL_IN,
  input wire logic SDA_OE,
  input wire logic ADDR_SELECT_LO,
  input wire logic ADDR_SELECT_HI,
  input wire logic BUS_ABORT_N,
  // port and interrupt drives
  input wire logic [7:0] OPEN_DRAIN_PORTS_OE,
  input wire logic [7:0] PUSH_PULL_PORTS_OUT,
  input wire logic [7:0] PUSH_PULL_PORTS_OE,
  input wire logic CHANGE_IRQ_N_OE
);
  // ----------------------------------------
  // single domain, reset disables all checks
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // first cycle out of reset shows the defaults
  reset_quiet_a: assert property (
    $fell(SYS_RST) |-> !SDA_OE && !CHANGE_IRQ_N_OE && PUSH_PULL_PORTS_OE == 8'hFF && OPEN_DRAIN_PORTS_OE == 8'h00)
    else $error("reset defaults wrong");
  // straps reach the output registers in nibbles
  strap_load_a: assert property (
    $fell(SYS_RST) |-> ##8 PUSH_PULL_PORTS_OUT == {{4{ADDR_SELECT_HI}}, {4{ADDR_SELECT_LO}}}
    && OPEN_DRAIN_PORTS_OE == ~{{4{ADDR_SELECT_HI}}, {4{ADDR_SELECT_LO}}} && PUSH_PULL_PORTS_OE == 8'hFF)
    else $error("strap defaults wrong");
  // abort leaves sda released
  abort_frees_sda_a: assert property (
    !BUS_ABORT_N [*6] |-> !SDA_OE) else $error("sda held in abort");
  // abort never clears a pending change
  abort_keeps_irq_a: assert property (
    !BUS_ABORT_N && $past(BUS_ABORT_N, 3) == 1'b0 && CHANGE_IRQ_N_OE |=> CHANGE_IRQ_N_OE)
    else $error("abort cleared interrupt");
  // interrupt only releases inside an acknowledge
  irq_clear_ack_a: assert property (
    $fell(CHANGE_IRQ_N_OE) |-> SDA_OE || $past(SDA_OE)) else $error("interrupt cleared outside ack");
  // pulling sda while scl high would fake a start
  no_fake_start_a: assert property (
    $rose(SDA_OE) |-> !SCL_IN) else $error("sda pulled with scl high");
  // a driven low covers a whole clock phase
  ack_span_a: assert property (
    $rose(SDA_OE) |-> SDA_OE [*8]) else $error("sda low too short");
  // sda steady over the first half of the scl high phase
  hold_high_a: assert property (
    $rose(SCL_IN) |=> $stable(SDA_OE) [*4]) else $error("sda moved with scl high");
endmodule

/* File: iox_expander_tb_top.sv */
// self-checking bench for the expander
`include "iox_params.svh"
module iox_expander_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, abt_n = 1, hi = 0, lo = 0, look = 0, sda_oe, c_oe, irq_oe, scl, got, sda_o, irq_o;
  logic [7:0] od_ext = 8'hFF, pp_ext = 8'h00, dat, od_oe, od_o, pp_oe, pp_out, r, s, v[8];
  logic [7:0] q[$]; // expected results, oldest first
  logic [6:0] adr;
  int err_count = 0, checked = 0, seed = 32'h3DE5;
  // pull-ups on sda, the interrupt line and the open-drain group
  wire sda = (sda_oe ? sda_o : 1'b1) & !c_oe;
  wire irq_n = irq_oe ? irq_o : 1'b1;
  wire [7:0] od_pin = od_ext & (od_o | ~od_oe);
  wire [7:0] pp_pin = (pp_oe & pp_out) | (~pp_oe & pp_ext);
  always #20 clk = ~clk;
  iox_expander iox_expander_inst (.CLK(clk), .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE(sda_oe), .ADDR_SELECT_LO(lo), .ADDR_SELECT_HI(hi), .BUS_ABORT_N(abt_n), .OPEN_DRAIN_PORTS_IN(od_pin),
    .OPEN_DRAIN_PORTS_OUT(od_o), .OPEN_DRAIN_PORTS_OE(od_oe), .PUSH_PULL_PORTS_IN(pp_pin), .PUSH_PULL_PORTS_OUT(pp_out),
    .PUSH_PULL_PORTS_OE(pp_oe), .CHANGE_IRQ_N_OUT(irq_o), .CHANGE_IRQ_N_OE(irq_oe));
  iox_ctl_model iox_ctl_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_oe(c_oe), .got(got), .dat(dat));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // watcher: a finished transfer or probe takes the oldest note
  always @(posedge clk) begin
    if (got) chk(dat, q.pop_front());
    if (look) chk({7'h00, !irq_n}, q.pop_front());
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // settle time covers the pin synchronisers
  task automatic probe(input logic e);
    w(20); q.push_back({7'h00, e}); look <= 1; w(1); look <= 0;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    q.push_back(8'h01); iox_ctl_model_inst.wr(adr, c, d);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    q.push_back(e); iox_ctl_model_inst.rd(adr, c);
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog, well past the expected run length
  initial begin
    w(60000); err_count++; results;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {hi, lo} = 2'($random(seed));
    adr = {`IOX_ADDR_HI, hi, lo};
    s = {{4{hi}}, {4{lo}}};
    w(10); rst <= 0; w(12);
    for (int c = 2; c < 8; c++) rd(8'(c), c < 4 ? s : 8'h00);
    probe(0);
    $display("test reset defaults done");
    for (int c = 2; c < 8; c++) begin
      r = 8'($random(seed)); v[c] = r; wr(8'(c), r); rd(8'(c), r);
    end
    pp_ext <= 8'($random(seed)); r = 8'($random(seed)); wr(3, 8'h3C); wr(5, r);
    rd(1, (r & pp_ext) | (~r & 8'h3C));
    v[5] = r;
    $display("test register access done");
    // mask first and release the pins high, unmask once they have settled
    wr(6, 8'hFF); wr(2, 8'hFF); wr(4, 8'hFF);
    wr(5, 8'h00); wr(3, 8'h5A); wr(6, 8'h00); rd(0, 8'hFF); rd(1, 8'h5A);
    probe(0); wr(3, 8'hA5); probe(0);
    od_ext <= 8'hF7; probe(1);
    rd(1, 8'hA5); probe(1);
    abt_n <= 0; w(16); abt_n <= 1; probe(1);
    rd(0, 8'hF7); probe(0);
    wr(6, 8'h01); od_ext <= 8'hF6; probe(0);
    fork
      rd(0, 8'hF6);
      begin w(520); od_ext <= 8'hE6; end
    join
    probe(1);
    $display("test change detection done");
    adr[0] = ~adr[0]; q.push_back(8'h00); iox_ctl_model_inst.wr(adr, 8'h07, ~v[7]); adr[0] = ~adr[0];
    fork
      begin q.push_back(8'h00); iox_ctl_model_inst.wr(adr, 8'h07, ~v[7]); end
      begin w(58); abt_n <= 0; w(16); abt_n <= 1; end
    join
    rd(7, v[7]);
    $display("test address and abort done");
    results;
  end
endmodule
bind iox_expander iox_expander_chk iox_expander_chk_inst (.CLK, .SYS_RST, .SCL_IN, .SDA_OE, .ADDR_SELECT_LO,
  .ADDR_SELECT_HI, .BUS_ABORT_N, .OPEN_DRAIN_PORTS_OE, .PUSH_PULL_PORTS_OUT, .PUSH_PULL_PORTS_OE, .CHANGE_IRQ_N_OE);

/* File: iox_filter.sv */
// two-flop synchroniser plus glitch filter for one serial line
module iox_filter
  import iox_pkg::*;
#(
  parameter int unsigned LEN = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pin and cleaned level
  input wire logic pin,
  output logic level
);
`include "iox_params.svh"
  logic s1_ff; // first stage, read only by s2
  logic s2_ff; // second stage
  logic [3:0] cnt_ff; // agreement counter
  logic [3:0] nxt_cnt;
  logic nxt_level;
  logic differs;
  // ----------------------------------------
  // filter decisions
  // ----------------------------------------
  assign differs = (s2_ff != level);
  // a new level must hold LEN cycles; shorter spikes are dropped
  assign nxt_cnt = differs ? cnt_ff + 4'h1 : 4'h0;
  assign nxt_level = (differs && (nxt_cnt >= 4'(LEN))) ? s2_ff : level;
  // ----------------------------------------
  // registers; lines idle high
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      cnt_ff <= 4'h0;
      level <= 1'b1;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      cnt_ff <= (nxt_level != level) ? 4'h0 : nxt_cnt;
      level <= nxt_level;
    end
  end
endmodule

/* File: iox_params.svh */
// constants for the sixteen-port i2c expander with change detection
`ifndef IOX_PARAMS_SVH
`define IOX_PARAMS_SVH
// ----------------------------------------
// target address
// ----------------------------------------
`define IOX_ADDR_HI 5'h16
// ----------------------------------------
// command byte register selects
// ----------------------------------------
`define IOX_CMD_IN_A 3'h0
`define IOX_CMD_IN_B 3'h1
`define IOX_CMD_OUT_A 3'h2
`define IOX_CMD_OUT_B 3'h3
`define IOX_CMD_DIR_A 3'h4
`define IOX_CMD_DIR_B 3'h5
`define IOX_CMD_MSK_A 3'h6
`define IOX_CMD_MSK_B 3'h7
// ----------------------------------------
// reset values
// ----------------------------------------
`define IOX_DIR_RST 8'h00
`define IOX_MSK_RST 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define IOX_CLK_NS 40
`define IOX_SPIKE_NS 50
// glitch filter length in cycles: a spike of 50 ns must not pass, round up; a 50 ns spike sampled on two edges still passes
`define IOX_FILT_CYC ((`IOX_SPIKE_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS)
`endif

/* File: iox_pkg.sv */
// types shared by the expander design files
package iox_pkg;
  // serial engine states
  typedef enum logic [2:0] {
    IOX_IDLE = 3'b000,
    IOX_ADDR = 3'b001,
    IOX_AACK = 3'b010,
    IOX_WBYT = 3'b011,
    IOX_WACK = 3'b100,
    IOX_RBYT = 3'b101,
    IOX_RACK = 3'b110
  } iox_state_e;
  // one 8-bit port group
  typedef struct packed {
    logic [7:0] outv;
    logic [7:0] dir;
    logic [7:0] msk;
  } iox_group_s;
  // the two serial bus lines after filtering
  typedef struct packed {
    logic scl;
    logic sda;
  } iox_bus_s;
endpackage
